// ==== hw/fsspi_pkg.sv ====
/*
 * Shared constants of the serial memory slave: op-codes, status layout,
 * memory geometry and the command phase.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package fsspi_pkg;
    // ------------------------------------------------------------
    // Geometry.
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DEPTH = 16384;
    localparam int ADDR_BITS_IN = 16;

    // ------------------------------------------------------------
    // Op-codes.
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_WL = 8'h06;
    localparam logic [7:0] OP_CLR_WL = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_RD_ID = 8'h9f;
    localparam logic [7:0] OP_SLEEP = 8'hb9;

    // ------------------------------------------------------------
    // Status register fields and reset value.
    // ------------------------------------------------------------
    localparam int ST_GUARD = 7;
    localparam int ST_WEL = 1;
    localparam logic [7:0] ST_NV_MASK = 8'hfc;
    localparam logic [7:0] ST_NV_RESET = 8'h00;
    localparam logic [31:0] IDENT_WORD = 32'h01234567; // Arbitrary identity value.

    // Command phase of the slave.
    typedef enum logic [2:0] {
        FSSPI_OPCODE, FSSPI_ADDR, FSSPI_RDATA, FSSPI_WDATA, FSSPI_STAT_WR, FSSPI_RSTAT, FSSPI_ID, FSSPI_IGNORE
    } fsspi_phase_e;
endpackage : fsspi_pkg

// ==== hw/fsspi_slave.sv ====
/*
 * Serial slave of a 16K x 8 nonvolatile memory, pin level.
 * Assumes the master clock is far slower than clk (pins are synchronised
 * and edges detected on clk), and that the master keeps chip select low
 * through a hold and before the first op-code bit.
 */
// Overview of operation
// - Chip select high: standby, output floated.
// - Deselected: ignore clock, data, hold, protect.
// - Hold low pauses transfer, floats output.
// - Sample data input on rising clock.
// - Change data output on falling clock.
// - Input carries op-code, address, write data.
// - Output carries only read data, status, identity.
// - Works in clock modes 0 and 3; sleep lasts in mode 3 only, as the closing mode 0 clock fall wakes it.
// - Status write gated by pin and guard.
// - Array of 16384 bytes, 14-bit address.
// - Eight op-codes; select rise cancels op-code.
// - Status layout: guard, spare, protect, latch, zero.
// - Writes need latch; latch cleared by clear command.
// - Read: 16-bit address, auto increment, wraps.
`timescale 1ns/100ps
module fsspi_slave #(
    parameter int ADDR_W = fsspi_pkg::ADDR_W,
    parameter int DEPTH = fsspi_pkg::DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins.
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic hold_n,
    input wire logic wprot_n,
    output logic sdo,
    output logic sdo_oe_n,
    // Status seen by the system.
    output logic write_enable_latch,
    output logic asleep
);
    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    logic [4:0] s1_r, s2_r;
    logic sclk_d_r;
    // Two stages per pin; only s2 is read by logic.
    // Reset values are the idle pin levels, so no false clock edge or hold follows reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 5'h1b;
            s2_r <= 5'h1b;
            sclk_d_r <= 1'b1;
        end else begin
            s1_r <= {sel_n, sclk, sdi, hold_n, wprot_n};
            s2_r <= s1_r;
            sclk_d_r <= s2_r[3];
        end
    end
    logic sel_q, sclk_q, sdi_q, hold_q, wp_q;
    assign sel_q = s2_r[4];
    assign sclk_q = s2_r[3];
    assign sdi_q = s2_r[2];
    assign hold_q = s2_r[1];
    assign wp_q = s2_r[0];

    // Edges count only while selected and not held; mode 0 and 3 both use these edges.
    logic active, rise, fall;
    assign active = !sel_q && hold_q;
    assign rise = active && sclk_q && !sclk_d_r;
    assign fall = active && !sclk_q && sclk_d_r;

    // ------------------------------------------------------------
    // Memory and status.
    // ------------------------------------------------------------
    logic [7:0] mem [DEPTH];
    logic [7:0] stat_nv_r;
    logic wel_r;
    logic [7:0] status;
    assign status = {stat_nv_r[7:2], wel_r, 1'b0};

    // ------------------------------------------------------------
    // Shifter and decoder.
    // ------------------------------------------------------------
    fsspi_pkg::fsspi_phase_e phase_r;
    logic [4:0] cnt_r;
    logic [7:0] sh_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0] out_r;
    logic [1:0] id_idx_r;
    logic out_r_cmd_is_write;
    logic [7:0] byte_in;
    assign byte_in = {sh_r[6:0], sdi_q};

    // Input shift, bit counter and command phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= fsspi_pkg::FSSPI_OPCODE;
            cnt_r <= 5'h00;
            sh_r <= 8'h00;
            addr_r <= '0;
            id_idx_r <= 2'h0;
            out_r_cmd_is_write <= 1'b0;
        end else if (sel_q) begin
            phase_r <= fsspi_pkg::FSSPI_OPCODE;
            cnt_r <= 5'h00;
        end else if (rise) begin
            sh_r <= byte_in;
            cnt_r <= cnt_r + 5'h01;
            case (phase_r)
                fsspi_pkg::FSSPI_OPCODE: begin
                    if (cnt_r == 5'h07) begin
                        cnt_r <= 5'h00;
                        case (byte_in)
                            fsspi_pkg::OP_RD_STAT: phase_r <= fsspi_pkg::FSSPI_RSTAT;
                            fsspi_pkg::OP_WR_STAT: phase_r <= fsspi_pkg::FSSPI_STAT_WR;
                            fsspi_pkg::OP_READ, fsspi_pkg::OP_WRITE: phase_r <= fsspi_pkg::FSSPI_ADDR;
                            fsspi_pkg::OP_RD_ID: phase_r <= fsspi_pkg::FSSPI_ID;
                            default: phase_r <= fsspi_pkg::FSSPI_IGNORE;
                        endcase
                        id_idx_r <= 2'h0;
                        addr_r <= '0;
                        out_r_cmd_is_write <= (byte_in == fsspi_pkg::OP_WRITE);
                    end
                end
                fsspi_pkg::FSSPI_ADDR: begin
                    addr_r <= {addr_r[ADDR_W-2:0], sdi_q};
                    if (cnt_r == 5'h0f) begin
                        cnt_r <= 5'h00;
                        phase_r <= out_r_cmd_is_write ? fsspi_pkg::FSSPI_WDATA : fsspi_pkg::FSSPI_RDATA;
                    end
                end
                fsspi_pkg::FSSPI_RDATA, fsspi_pkg::FSSPI_WDATA: begin
                    if (cnt_r == 5'h07) begin
                        cnt_r <= 5'h00;
                        addr_r <= addr_r + 1'b1;
                    end
                end
                fsspi_pkg::FSSPI_ID, fsspi_pkg::FSSPI_RSTAT, fsspi_pkg::FSSPI_STAT_WR: begin
                    if (cnt_r == 5'h07) begin
                        cnt_r <= 5'h00;
                        id_idx_r <= id_idx_r + 2'h1;
                        if (phase_r == fsspi_pkg::FSSPI_STAT_WR) phase_r <= fsspi_pkg::FSSPI_IGNORE;
                    end
                end
                default: cnt_r <= 5'h00;
            endcase
        end
    end

    // Complete op-code or data byte on this rising edge.
    logic op_done, byte_done;
    assign op_done = rise && phase_r == fsspi_pkg::FSSPI_OPCODE && cnt_r == 5'h07;
    assign byte_done = rise && cnt_r == 5'h07;

    // Latch: set and clear commands only; select rise leaves it alone.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wel_r <= 1'b0;
        else if (op_done && byte_in == fsspi_pkg::OP_SET_WL) wel_r <= 1'b1;
        else if (op_done && byte_in == fsspi_pkg::OP_CLR_WL) wel_r <= 1'b0;
    end

    // Status write needs the latch and no guard with the protect pin low.
    logic stat_wr_ok;
    assign stat_wr_ok = wel_r && !(stat_nv_r[fsspi_pkg::ST_GUARD] && !wp_q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) stat_nv_r <= fsspi_pkg::ST_NV_RESET;
        else if (byte_done && phase_r == fsspi_pkg::FSSPI_STAT_WR && stat_wr_ok)
            stat_nv_r <= byte_in & fsspi_pkg::ST_NV_MASK;
    end

    // Array write; block protect is kept but not enforced here.
    always_ff @(posedge clk) begin
        if (byte_done && phase_r == fsspi_pkg::FSSPI_WDATA && wel_r)
            mem[addr_r] <= byte_in;
    end

    // Sleep entered by its op-code, left on the first falling clock edge while selected.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) asleep <= 1'b0;
        else if (op_done && byte_in == fsspi_pkg::OP_SLEEP) asleep <= 1'b1;
        else if (!sel_q && !sclk_q && sclk_d_r) asleep <= 1'b0;
    end

    // ------------------------------------------------------------
    // Output launch on falling clock edges.
    // ------------------------------------------------------------
    logic [7:0] next_byte;
    always_comb begin
        case (phase_r)
            fsspi_pkg::FSSPI_RDATA: next_byte = mem[addr_r];
            fsspi_pkg::FSSPI_RSTAT: next_byte = status;
            fsspi_pkg::FSSPI_ID: next_byte = fsspi_pkg::IDENT_WORD[8*(3-id_idx_r) +: 8];
            default: next_byte = 8'h00;
        endcase
    end
    logic reading;
    assign reading = phase_r == fsspi_pkg::FSSPI_RDATA || phase_r == fsspi_pkg::FSSPI_RSTAT
                     || phase_r == fsspi_pkg::FSSPI_ID;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 8'h00;
            sdo <= 1'b0;
        end else if (fall && reading) begin
            if (cnt_r == 5'h00) begin
                sdo <= next_byte[7];
                out_r <= {next_byte[6:0], 1'b0};
            end else begin
                sdo <= out_r[7];
                out_r <= {out_r[6:0], 1'b0};
            end
        end
    end

    // Output enabled only when selected, not held and sending read data, status or identity.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sdo_oe_n <= 1'b1;
        else if (!active || !reading) sdo_oe_n <= 1'b1;
        else if (fall) sdo_oe_n <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) write_enable_latch <= 1'b0;
        else write_enable_latch <= wel_r;
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_standby_float;
        @(posedge clk) disable iff (!rst_n) sel_q |=> sdo_oe_n;
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("output driven in standby");
    property p_hold_float;
        @(posedge clk) disable iff (!rst_n) (!sel_q && !hold_q) |=> sdo_oe_n;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("output driven in hold");
    property p_desel_phase;
        @(posedge clk) disable iff (!rst_n) sel_q |=> phase_r == fsspi_pkg::FSSPI_OPCODE && cnt_r == 5'h00;
    endproperty
    a_desel_phase: assert property (p_desel_phase) else $error("decoder not reset");
    property p_fresh;
        @(posedge clk) disable iff (!rst_n) $rose(sel_q) |=> cnt_r == 5'h00;
    endproperty
    a_fresh: assert property (p_fresh) else $error("counter not cleared");
    property p_sample;
        @(posedge clk) disable iff (!rst_n) rise |=> sh_r[0] == $past(sdi_q);
    endproperty
    a_sample: assert property (p_sample) else $error("input not sampled on rise");
    property p_launch;
        @(posedge clk) disable iff (!rst_n) (!fall && !sdo_oe_n) |=> $stable(sdo);
    endproperty
    a_launch: assert property (p_launch) else $error("output changed off falling edge");
    property p_wel_set;
        @(posedge clk) disable iff (!rst_n) (op_done && byte_in == fsspi_pkg::OP_SET_WL) |=> ##1 write_enable_latch;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");
    property p_stat_guard;
        @(posedge clk) disable iff (!rst_n)
            (!wel_r || (stat_nv_r[fsspi_pkg::ST_GUARD] && !wp_q)) |=> $stable(stat_nv_r) || !$past(byte_done);
    endproperty
    a_stat_guard: assert property (p_stat_guard) else $error("protected status written");
    property p_zero_bits;
        @(posedge clk) disable iff (!rst_n) stat_nv_r[1:0] == 2'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("status low bits nonzero");
    c_read: cover property (@(posedge clk) phase_r == fsspi_pkg::FSSPI_RDATA && byte_done);
    c_write: cover property (@(posedge clk) phase_r == fsspi_pkg::FSSPI_WDATA && byte_done && wel_r);
    c_hold: cover property (@(posedge clk) !sel_q && !hold_q);
endmodule : fsspi_slave

// ==== bench/fsspi_master.sv ====
/*
 * Model of the serial bus master that drives the slave's pins.
 * Assumes clk runs at 10 MHz; one serial bit spans 8 clk cycles (800 ns).
 */
`timescale 1ns/100ps
module fsspi_master (
    // System clock.
    input wire logic clk,
    // Serial pins.
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    output logic hold_n,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic mode3 = 1'b0;
    // Idle pins at time zero.
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        hold_n = 1'b1;
    end
    // Every step lands just after a clock edge so no race is possible.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Select goes low only after the clock has settled at its idle level, so a
    // mode change never shows the slave a clock edge while it is selected.
    task automatic start();
        sclk = mode3;
        tick(4);
        sel_n = 1'b0;
        tick(4);
    endtask : start
    // A released input line shows the inverse of its last value.
    task automatic stop();
        sclk = mode3;
        tick(4);
        sel_n = 1'b1;
        sdi = ~sdi;
        tick(4);
    endtask : stop
    // Launch on the low phase; read back mid high phase, well after the fall.
    task automatic xbit(input logic b, output logic r);
        sclk = 1'b0;
        sdi = b;
        tick(4);
        sclk = 1'b1;
        tick(2);
        r = sdo;
        tick(2);
    endtask : xbit
    task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) xbit(t[i], r[i]);
    endtask : xbyte
    // Hold with select kept low; the clock wiggles, which must be ignored.
    task automatic pause(output logic oe);
        hold_n = 1'b0;
        tick(8);
        oe = sdo_oe_n;
        sclk = 1'b0;
        sdi = ~sdi;
        tick(2);
        sclk = 1'b1;
        tick(2);
        hold_n = 1'b1;
        tick(4);
    endtask : pause
endmodule : fsspi_master

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench of the serial memory slave, driven by the master model.
 * Assumes the slave and its package are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
    typedef struct {logic [15:0] a; logic [7:0] d;} fsspi_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wprot_n = 1'b1;
    logic sel_n, sclk, sdi, hold_n, sdo, sdo_oe_n, write_enable_latch, asleep, o;
    logic [7:0] r;
    int n_errors = 0;
    int comparisons = 0;
    // Top address bits set in the last row must be ignored.
    fsspi_row_s rows[3] = '{'{16'h0000, 8'h5a}, '{16'h3fff, 8'ha5}, '{16'hc005, 8'h3c}};
    always #50 clk = ~clk;
    fsspi_slave fsspi_slave_inst (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
        .hold_n(hold_n), .wprot_n(wprot_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .write_enable_latch(write_enable_latch), .asleep(asleep));
    fsspi_master fsspi_master_inst (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .hold_n(hold_n),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic op(input logic [7:0] c, input logic [7:0] d, input int n);
        fsspi_master_inst.start();
        fsspi_master_inst.xbyte(c, r);
        if (n > 1) fsspi_master_inst.xbyte(d, r);
        fsspi_master_inst.stop();
    endtask : op
    // Opens a memory command and leaves select low for the data bytes.
    task automatic hdr(input logic [7:0] c, input logic [15:0] a);
        fsspi_master_inst.start();
        fsspi_master_inst.xbyte(c, r);
        fsspi_master_inst.xbyte(a[15:8], r);
        fsspi_master_inst.xbyte(a[7:0], r);
    endtask : hdr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        hdr(fsspi_pkg::OP_READ, a);
        fsspi_master_inst.xbyte(8'h00, r);
        fsspi_master_inst.stop();
        check("rdata", exp, r);
    endtask : rd
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // A hang is cut short well inside the cycle budget.
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    // Main sequence: reset, ignored and cancelled commands, table rows, then the awkward cases.
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        check("oe_n", 8'h01, {7'h00, sdo_oe_n});
        for (int i = 7; i >= 0; i--) fsspi_master_inst.xbit(fsspi_pkg::OP_SET_WL[i], o);
        fsspi_master_inst.stop();
        check("latch", 8'h00, {7'h00, write_enable_latch});
        fsspi_master_inst.start();
        for (int i = 7; i >= 4; i--) fsspi_master_inst.xbit(fsspi_pkg::OP_SET_WL[i], o);
        fsspi_master_inst.stop();
        check("latch", 8'h00, {7'h00, write_enable_latch});
        op(fsspi_pkg::OP_SET_WL, 8'h00, 1);
        foreach (rows[i]) begin
            hdr(fsspi_pkg::OP_WRITE, rows[i].a);
            fsspi_master_inst.xbyte(rows[i].d, r);
            fsspi_master_inst.stop();
            check("latch", 8'h01, {7'h00, write_enable_latch});
            rd(rows[i].a & 16'h3fff, rows[i].d);
        end
        hdr(fsspi_pkg::OP_READ, 16'h3fff);
        fsspi_master_inst.xbyte(8'h00, r);
        check("wrap0", 8'ha5, r);
        fsspi_master_inst.xbyte(8'h00, r);
        check("wrap1", 8'h5a, r);
        fsspi_master_inst.stop();
        op(fsspi_pkg::OP_WR_STAT, 8'h83, 2);
        op(fsspi_pkg::OP_RD_STAT, 8'h00, 2);
        check("status", 8'h82, r);
        wprot_n = 1'b0;
        op(fsspi_pkg::OP_WR_STAT, 8'h0c, 2);
        op(fsspi_pkg::OP_RD_STAT, 8'h00, 2);
        check("status", 8'h82, r);
        op(fsspi_pkg::OP_CLR_WL, 8'h00, 1);
        hdr(fsspi_pkg::OP_WRITE, 16'h0000);
        fsspi_master_inst.xbyte(8'h00, r);
        fsspi_master_inst.stop();
        rd(16'h0000, 8'h5a);
        hdr(fsspi_pkg::OP_READ, 16'h0005);
        for (int i = 7; i >= 4; i--) fsspi_master_inst.xbit(1'b0, r[i]);
        check("read_oe_n", 8'h00, {7'h00, sdo_oe_n});
        fsspi_master_inst.pause(o);
        check("hold_oe_n", 8'h01, {7'h00, o});
        for (int i = 3; i >= 0; i--) fsspi_master_inst.xbit(1'b0, r[i]);
        fsspi_master_inst.stop();
        check("hold_data", 8'h3c, r);
        fsspi_master_inst.mode3 = 1'b1;
        op(fsspi_pkg::OP_SET_WL, 8'h00, 1);
        hdr(fsspi_pkg::OP_WRITE, 16'h0100);
        fsspi_master_inst.xbyte(8'hc3, r);
        fsspi_master_inst.stop();
        rd(16'h0100, 8'hc3);
        op(fsspi_pkg::OP_RD_ID, 8'h00, 2);
        check("ident", fsspi_pkg::IDENT_WORD[31:24], r);
        op(fsspi_pkg::OP_SLEEP, 8'h00, 1);
        check("asleep", 8'h01, {7'h00, asleep});
        check("oe_n", 8'h01, {7'h00, sdo_oe_n});
        // A reset in mid-run must clear the latch and the sleep flag again.
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check("latch", 8'h00, {7'h00, write_enable_latch});
        check("asleep", 8'h00, {7'h00, asleep});
        check("oe_n", 8'h01, {7'h00, sdo_oe_n});
        wrap_up();
    end
endmodule : tb_top
